// ### rtl/sttf_taskfile.sv
module sttf_taskfile #(
  parameter int TICK_CYC = sttf_pkg::TICK_CYC
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [3:0] REG_SEL,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic INTRQ,
  input wire sttf_pkg::sttf_core_stat_t CORE_STAT,
  input wire sttf_pkg::sttf_cmpl_t CMPL,
  output logic CMPL_ACK,
  input wire sttf_pkg::sttf_cond_t COND,
  output logic CMD_START,
  output logic [7:0] CMD_CODE,
  output logic [47:0] CMD_ADDR,
  output logic [3:0] CMD_HEAD,
  output logic CMD_LBA_MODE,
  output logic [15:0] CMD_COMPLETION_TIME_LIMIT_MS,
  output logic SOFT_RESET,
  input wire logic COMRESET_REQ,
  output logic COMINIT_SEND
);

  typedef struct packed {
    sttf_pkg::sttf_state_t state;
    logic [7:0] devctl;
    logic [7:0] devhead;
    logic [7:0] err_reg;
    logic [7:0] cmd_code;
    logic err_flag;
    logic int_pend;
    logic [7:0] rdata;
    logic start;
    logic [15:0] completion_time_limit;
    logic [15:0] tick_cnt;
    logic [9:0] por_ticks;
    logic comreset_pend;
    logic cominit;
  } sttf_regs_t;

  sttf_regs_t s_r;
  sttf_regs_t s_nxt;

  logic [sttf_pkg::NUM_HIST-1:0] h_wr;
  logic [sttf_pkg::NUM_HIST-1:0] h_upd;
  logic [7:0] h_wdata;
  logic [7:0] h_cur [sttf_pkg::NUM_HIST];
  logic [7:0] h_prev [sttf_pkg::NUM_HIST];
  logic [7:0] h_upd_cur [sttf_pkg::NUM_HIST];
  logic [7:0] h_upd_prev [sttf_pkg::NUM_HIST];
  logic [7:0] status;
  logic busy;
  logic por_window;
  logic cmd_wr;
  logic cmpl_take;
  logic abort_cmd;
  logic hob;

  function automatic logic [15:0] clamp_completion_time_limit(input logic [15:0] req);
    clamp_completion_time_limit = (req < sttf_pkg::COMPLETION_TIME_LIMIT_MIN_MS) ? sttf_pkg::COMPLETION_TIME_LIMIT_MIN_MS : req;
  endfunction

  function automatic logic [7:0] pick(input logic [7:0] cur, input logic [7:0] prev, input logic hi);
    pick = hi ? prev : cur;
  endfunction

  genvar g;
  generate
    for (g = 0; g < sttf_pkg::NUM_HIST; g++) begin : g_hist
      sttf_hist_reg u_hist (
        .clk(CLK),
        .rst_b(RST_B),
        .wr(h_wr[g]),
        .wdata(h_wdata),
        .upd(h_upd[g]),
        .upd_cur(h_upd_cur[g]),
        .upd_prev(h_upd_prev[g]),
        .cur(h_cur[g]),
        .prev(h_prev[g])
      );
    end
  endgenerate

  assign busy = (s_r.state == sttf_pkg::STTF_EXEC);
  assign hob = s_r.devctl[sttf_pkg::DC_HOB];
  assign por_window = (s_r.por_ticks < sttf_pkg::POR_WINDOW_TICKS);

  // status byte shared by both status views
  always_comb begin
    status = 8'h00;
    status[sttf_pkg::ST_OCCUPIED] = busy;
    status[sttf_pkg::ST_READY] = CORE_STAT.ready;
    status[sttf_pkg::ST_FAULT] = 1'b0;
    status[sttf_pkg::ST_SEEK] = CORE_STAT.seek_done;
    status[sttf_pkg::ST_DREQ] = CORE_STAT.data_req;
    status[sttf_pkg::ST_CORR] = 1'b0;
    status[sttf_pkg::ST_INDEX] = CORE_STAT.index;
    status[sttf_pkg::ST_ERR] = s_r.err_flag;
  end

  assign cmd_wr = REG_WR && (REG_SEL == sttf_pkg::IDX_STAT_CMD) && !busy && !SOFT_RESET;
  assign abort_cmd = (COND.sec_locked && ((REG_WDATA == sttf_pkg::CMD_DL_MCODE) ||
                     (REG_WDATA == sttf_pkg::CMD_DL_MCODE_DMA))) ||
                     (COND.erc_valid && (COND.erc_units < sttf_pkg::ERC_MIN_UNITS));
  assign cmpl_take = busy && CMPL.done && !COND.spin_up;
  assign CMPL_ACK = cmpl_take;

  // history register writes and end-of-command updates
  always_comb begin
    h_wdata = REG_WDATA;
    h_wr = '0;
    h_upd = '0;
    if (REG_WR && !busy && !SOFT_RESET) begin
      case (REG_SEL)
        sttf_pkg::IDX_FEAT: h_wr[sttf_pkg::H_FEAT] = 1'b1;
        sttf_pkg::IDX_COUNT: h_wr[sttf_pkg::H_COUNT] = 1'b1;
        sttf_pkg::IDX_SECNUM: h_wr[sttf_pkg::H_SECNUM] = 1'b1;
        sttf_pkg::IDX_CYL_LOW: h_wr[sttf_pkg::H_CYL_LOW] = 1'b1;
        sttf_pkg::IDX_CYL_HIGH: h_wr[sttf_pkg::H_CYL_HIGH] = 1'b1;
        default: h_wr = '0;
      endcase
    end
    if (cmpl_take) begin
      h_upd[sttf_pkg::H_COUNT] = 1'b1;
      h_upd[sttf_pkg::H_SECNUM] = 1'b1;
      h_upd[sttf_pkg::H_CYL_LOW] = 1'b1;
      h_upd[sttf_pkg::H_CYL_HIGH] = 1'b1;
    end
    h_upd_cur[sttf_pkg::H_FEAT] = h_cur[sttf_pkg::H_FEAT];
    h_upd_prev[sttf_pkg::H_FEAT] = h_prev[sttf_pkg::H_FEAT];
    h_upd_cur[sttf_pkg::H_COUNT] = CMPL.count;
    if (s_r.cmd_code == sttf_pkg::CMD_CHK_POWER && COND.idle) begin
      h_upd_cur[sttf_pkg::H_COUNT] = COND.epc_enabled ? sttf_pkg::PWR_IDLE_EPC_ON :
                                     sttf_pkg::PWR_IDLE_EPC_OFF;
    end
    h_upd_prev[sttf_pkg::H_COUNT] = h_prev[sttf_pkg::H_COUNT];
    h_upd_cur[sttf_pkg::H_SECNUM] = CMPL.addr[7:0];
    h_upd_prev[sttf_pkg::H_SECNUM] = CMPL.addr[31:24];
    h_upd_cur[sttf_pkg::H_CYL_LOW] = CMPL.addr[15:8];
    h_upd_prev[sttf_pkg::H_CYL_LOW] = CMPL.addr[39:32];
    h_upd_cur[sttf_pkg::H_CYL_HIGH] = CMPL.addr[23:16];
    h_upd_prev[sttf_pkg::H_CYL_HIGH] = CMPL.addr[47:40];
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.cominit = 1'b0;

    // 1 ms enable and power-on window count
    if (s_r.tick_cnt == 16'(TICK_CYC - 1)) begin
      s_nxt.tick_cnt = 16'h0000;
      if (por_window) begin
        s_nxt.por_ticks = s_r.por_ticks + 10'h001;
      end
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
    end

    // link reset reply held back inside the power-on window
    if (COMRESET_REQ) begin
      s_nxt.comreset_pend = 1'b1;
    end else if (s_r.comreset_pend && !por_window) begin
      s_nxt.comreset_pend = 1'b0;
      s_nxt.cominit = 1'b1;
    end

    // register reads
    if (REG_RD) begin
      if (busy) begin
        s_nxt.rdata = status;
      end else begin
        case (REG_SEL)
          sttf_pkg::IDX_FEAT: s_nxt.rdata = s_r.err_reg;
          sttf_pkg::IDX_COUNT: s_nxt.rdata = pick(h_cur[sttf_pkg::H_COUNT], h_prev[sttf_pkg::H_COUNT], hob);
          sttf_pkg::IDX_SECNUM: s_nxt.rdata = pick(h_cur[sttf_pkg::H_SECNUM], h_prev[sttf_pkg::H_SECNUM], hob);
          sttf_pkg::IDX_CYL_LOW: s_nxt.rdata = pick(h_cur[sttf_pkg::H_CYL_LOW],
                                                    h_prev[sttf_pkg::H_CYL_LOW], hob);
          sttf_pkg::IDX_CYL_HIGH: s_nxt.rdata = pick(h_cur[sttf_pkg::H_CYL_HIGH],
                                                     h_prev[sttf_pkg::H_CYL_HIGH], hob);
          sttf_pkg::IDX_DEVHEAD: s_nxt.rdata = s_r.devhead;
          sttf_pkg::IDX_STAT_CMD: s_nxt.rdata = status;
          sttf_pkg::IDX_ALT_DEVCTL: s_nxt.rdata = status;
          default: s_nxt.rdata = 8'h00;
        endcase
      end
      if (REG_SEL == sttf_pkg::IDX_STAT_CMD) begin
        s_nxt.int_pend = 1'b0;
      end
    end

    // register writes
    if (REG_WR) begin
      if (REG_SEL == sttf_pkg::IDX_ALT_DEVCTL) begin
        s_nxt.devctl = REG_WDATA;
      end else if (REG_SEL == sttf_pkg::IDX_DEVHEAD && !busy && !SOFT_RESET) begin
        s_nxt.devhead = REG_WDATA;
      end
    end

    if (cmd_wr) begin
      s_nxt.devctl[sttf_pkg::DC_HOB] = 1'b0;
      s_nxt.cmd_code = REG_WDATA;
      s_nxt.err_flag = 1'b0;
      s_nxt.int_pend = 1'b0;
      if (abort_cmd) begin
        s_nxt.err_reg = 8'h00;
        s_nxt.err_reg[sttf_pkg::ER_ABORT] = 1'b1;
        s_nxt.err_flag = 1'b1;
        s_nxt.int_pend = !s_r.devctl[sttf_pkg::DC_NIEN];
      end else begin
        s_nxt.state = sttf_pkg::STTF_EXEC;
        s_nxt.start = 1'b1;
        s_nxt.completion_time_limit = clamp_completion_time_limit(COND.completion_time_limit_ms);
      end
    end

    // command end; new interrupt wins over an acknowledge in the same cycle
    if (cmpl_take) begin
      s_nxt.state = sttf_pkg::STTF_IDLE;
      s_nxt.err_reg = CMPL.err_code;
      s_nxt.err_flag = CMPL.error;
      s_nxt.devhead[3:0] = CMPL.head;
      if (!s_r.devctl[sttf_pkg::DC_NIEN]) begin
        s_nxt.int_pend = 1'b1;
      end
    end

    // soft reset holds the block idle
    if (s_r.devctl[sttf_pkg::DC_SOFT_RESET]) begin
      s_nxt.state = sttf_pkg::STTF_IDLE;
      s_nxt.int_pend = 1'b0;
      s_nxt.err_flag = 1'b0;
      s_nxt.err_reg = sttf_pkg::RST_ERR;
      s_nxt.start = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_r.state <= sttf_pkg::STTF_IDLE;
      s_r.devctl <= sttf_pkg::RST_DEVCTL;
      s_r.devhead <= sttf_pkg::RST_DEVHEAD;
      s_r.err_reg <= sttf_pkg::RST_ERR;
      s_r.cmd_code <= sttf_pkg::RST_TF;
      s_r.err_flag <= 1'b0;
      s_r.int_pend <= 1'b0;
      s_r.rdata <= 8'h00;
      s_r.start <= 1'b0;
      s_r.completion_time_limit <= sttf_pkg::COMPLETION_TIME_LIMIT_MIN_MS;
      s_r.tick_cnt <= 16'h0000;
      s_r.por_ticks <= 10'h000;
      s_r.comreset_pend <= 1'b0;
      s_r.cominit <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign REG_RDATA = s_r.rdata;
  assign INTRQ = s_r.int_pend && !s_r.devctl[sttf_pkg::DC_NIEN];
  assign CMD_START = s_r.start;
  assign CMD_CODE = s_r.cmd_code;
  assign CMD_ADDR = {h_prev[sttf_pkg::H_CYL_HIGH], h_prev[sttf_pkg::H_CYL_LOW], h_prev[sttf_pkg::H_SECNUM],
                     h_cur[sttf_pkg::H_CYL_HIGH], h_cur[sttf_pkg::H_CYL_LOW], h_cur[sttf_pkg::H_SECNUM]};
  assign CMD_HEAD = s_r.devhead[3:0];
  assign CMD_LBA_MODE = s_r.devhead[sttf_pkg::DH_LBA];
  assign CMD_COMPLETION_TIME_LIMIT_MS = s_r.completion_time_limit;
  assign SOFT_RESET = s_r.devctl[sttf_pkg::DC_SOFT_RESET];
  assign COMINIT_SEND = s_r.cominit;

endmodule // sttf_taskfile

// ### rtl/sttf_pkg.sv
package sttf_pkg;

  // task-file register select codes
  localparam logic [3:0] IDX_FEAT = 4'h1;
  localparam logic [3:0] IDX_COUNT = 4'h2;
  localparam logic [3:0] IDX_SECNUM = 4'h3;
  localparam logic [3:0] IDX_CYL_LOW = 4'h4;
  localparam logic [3:0] IDX_CYL_HIGH = 4'h5;
  localparam logic [3:0] IDX_DEVHEAD = 4'h6;
  localparam logic [3:0] IDX_STAT_CMD = 4'h7;
  localparam logic [3:0] IDX_ALT_DEVCTL = 4'he;

  // history slots, one per feature, count and address register
  localparam int NUM_HIST = 5;
  localparam int H_FEAT = 0;
  localparam int H_COUNT = 1;
  localparam int H_SECNUM = 2;
  localparam int H_CYL_LOW = 3;
  localparam int H_CYL_HIGH = 4;

  // status bit positions
  localparam int ST_OCCUPIED = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_SEEK = 4;
  localparam int ST_DREQ = 3;
  localparam int ST_CORR = 2;
  localparam int ST_INDEX = 1;
  localparam int ST_ERR = 0;

  // device control, device/head and error fields
  localparam int DC_HOB = 7;
  localparam int DC_SOFT_RESET = 2;
  localparam int DC_NIEN = 1;
  localparam int ER_ABORT = 2;
  localparam int DH_LBA = 6;

  // reset values
  localparam logic [7:0] RST_TF = 8'h00;
  localparam logic [7:0] RST_DEVHEAD = 8'h00;
  localparam logic [7:0] RST_DEVCTL = 8'h00;
  localparam logic [7:0] RST_ERR = 8'h01;

  // command codes and power report codes
  localparam logic [7:0] CMD_CHK_POWER = 8'he5;
  localparam logic [7:0] CMD_DL_MCODE = 8'h92;
  localparam logic [7:0] CMD_DL_MCODE_DMA = 8'h93;
  localparam logic [7:0] PWR_IDLE_EPC_OFF = 8'hff;
  localparam logic [7:0] PWR_IDLE_EPC_ON = 8'h80;

  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int POR_WINDOW_MS = 500;
  localparam int COMINIT_MAX_MS = 10;
  localparam logic [9:0] POR_WINDOW_TICKS = 10'(POR_WINDOW_MS / TICK_MS);
  localparam logic [15:0] COMPLETION_TIME_LIMIT_MIN_MS = 16'h0032;
  localparam int ERC_UNIT_MS = 100;
  localparam real ERC_MIN_S = 6.5;
  localparam logic [15:0] ERC_MIN_UNITS = 16'(int'(ERC_MIN_S * 1000.0) / ERC_UNIT_MS);

  typedef struct packed {
    logic ready;
    logic seek_done;
    logic data_req;
    logic index;
  } sttf_core_stat_t;

  typedef struct packed {
    logic done;
    logic error;
    logic [47:0] addr;
    logic [3:0] head;
    logic [7:0] count;
    logic [7:0] err_code;
  } sttf_cmpl_t;

  typedef struct packed {
    logic idle;
    logic epc_enabled;
    logic sec_locked;
    logic spin_up;
    logic erc_valid;
    logic [15:0] erc_units;
    logic [15:0] completion_time_limit_ms;
  } sttf_cond_t;

  typedef enum logic [0:0] {
    STTF_IDLE = 1'b0,
    STTF_EXEC = 1'b1
  } sttf_state_t;

endpackage

// ### rtl/sttf_hist_reg.sv
// one task-file byte with its previous-content slot
module sttf_hist_reg (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic upd,
  input wire logic [7:0] upd_cur,
  input wire logic [7:0] upd_prev,
  output logic [7:0] cur,
  output logic [7:0] prev
);

  typedef struct packed {
    logic [7:0] cur;
    logic [7:0] prev;
  } sttf_hist_t;

  sttf_hist_t s_r;
  sttf_hist_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (upd) begin
      s_nxt.cur = upd_cur;
      s_nxt.prev = upd_prev;
    end else if (wr) begin
      s_nxt.prev = s_r.cur;
      s_nxt.cur = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= {sttf_pkg::RST_TF, sttf_pkg::RST_TF};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cur = s_r.cur;
  assign prev = s_r.prev;

endmodule // sttf_hist_reg

// ### tb/sttf_taskfile_asserts.sv
module sttf_taskfile_asserts #(
  parameter int TICK_CYC = 10
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [3:0] REG_SEL,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic INTRQ,
  input wire sttf_pkg::sttf_cmpl_t CMPL,
  input wire logic CMPL_ACK,
  input wire sttf_pkg::sttf_cond_t COND,
  input wire logic CMD_START,
  input wire logic [7:0] CMD_CODE,
  input wire logic [15:0] CMD_COMPLETION_TIME_LIMIT_MS,
  input wire logic SOFT_RESET,
  input wire logic COMRESET_REQ,
  input wire logic COMINIT_SEND
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN = 500 * TICK_CYC;
  logic [31:0] cnt_r;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // cycles since reset, saturating past the power-on window
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) cnt_r <= '0;
    else if (cnt_r < 32'(WIN + 8)) cnt_r <= cnt_r + 32'h1;
  end
  sequence s_cmd_wr;
    REG_WR && REG_SEL == sttf_pkg::IDX_STAT_CMD;
  endsequence
  sequence s_pend_rd(logic [3:0] s);
    REG_RD && !REG_WR && REG_SEL == s && INTRQ && !SOFT_RESET && !COMRESET_REQ;
  endsequence
  chk_start_cause: assert property (CMD_START |-> $past(REG_WR) &&
    $past(REG_SEL) == sttf_pkg::IDX_STAT_CMD && CMD_CODE == $past(REG_WDATA))
    else $error("command start without command write");
  chk_start_pulse: assert property (s_cmd_wr ##1 CMD_START |=> !CMD_START)
    else $error("command start longer than one cycle");
  chk_lock_abort: assert property (s_cmd_wr ##0 (COND.sec_locked &&
    (REG_WDATA == sttf_pkg::CMD_DL_MCODE || REG_WDATA == sttf_pkg::CMD_DL_MCODE_DMA)) |=> !CMD_START)
    else $error("download started while locked");
  chk_erc_abort: assert property (s_cmd_wr ##0 (COND.erc_valid &&
    COND.erc_units < sttf_pkg::ERC_MIN_UNITS) |=> !CMD_START)
    else $error("command started with short recovery limit");
  chk_completion_time_limit_floor: assert property (CMD_COMPLETION_TIME_LIMIT_MS >= sttf_pkg::COMPLETION_TIME_LIMIT_MIN_MS)
    else $error("time limit below floor");
  chk_ack_cause: assert property (CMPL_ACK |-> CMPL.done && !COND.spin_up)
    else $error("completion taken during spin-up");
  chk_alt_keep: assert property (s_pend_rd(sttf_pkg::IDX_ALT_DEVCTL) |=> INTRQ)
    else $error("alternate read cleared interrupt");
  chk_stat_ack: assert property (s_pend_rd(sttf_pkg::IDX_STAT_CMD) ##0 !CMPL_ACK |=> !INTRQ)
    else $error("status read left interrupt pending");
  chk_cominit_win: assert property (COMINIT_SEND |-> cnt_r >= 32'(WIN - 2))
    else $error("link reset answered inside power-on window");
  chk_cominit_late: assert property (COMRESET_REQ && cnt_r > 32'(WIN + 4) |-> ##2 COMINIT_SEND)
    else $error("link reset not answered after window");
endmodule // sttf_taskfile_asserts

bind sttf_taskfile sttf_taskfile_asserts #(.TICK_CYC(TICK_CYC)) sttf_taskfile_asserts_i (.*);

// ### tb/sttf_core_model.sv
// device core: finishes each started command dly+2 cycles after CMD_START
module sttf_core_model (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CMD_START,
  input wire logic CMPL_ACK,
  input wire logic [7:0] dly,
  input wire logic [47:0] end_addr,
  input wire logic [7:0] end_count,
  output sttf_pkg::sttf_cmpl_t cmpl
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cmpl <= '0;
      cnt <= 0;
    end else if (cmpl.done) begin
      // released fields no longer show the taken value
      if (CMPL_ACK) cmpl <= {2'b00, ~cmpl.addr, ~cmpl.head, ~cmpl.count, ~cmpl.err_code};
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) cmpl <= {2'b10, end_addr, 4'h0, end_count, 8'h00};
    end else if (CMD_START) cnt <= int'(dly) + 1;
  end
endmodule // sttf_core_model

// ### tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0;
  logic RST_B = 0;
  logic [3:0] REG_SEL = '0;
  logic REG_WR = 0;
  logic REG_RD = 0;
  logic [7:0] REG_WDATA = '0;
  logic COMRESET_REQ = 0;
  sttf_pkg::sttf_core_stat_t CORE_STAT = '0;
  sttf_pkg::sttf_cond_t COND = '0;
  sttf_pkg::sttf_cmpl_t CMPL;
  logic [7:0] REG_RDATA, CMD_CODE;
  logic INTRQ, CMPL_ACK, CMD_START, CMD_LBA_MODE, SOFT_RESET, COMINIT_SEND;
  logic [47:0] CMD_ADDR;
  logic [3:0] CMD_HEAD;
  logic [15:0] CMD_COMPLETION_TIME_LIMIT_MS;
  logic [7:0] dly = 8'h03;
  logic [47:0] eaddr = '0;
  logic [7:0] ecnt = '0;
  logic rd_d = 0;
  logic [15:0] expq[$];
  logic [47:0] addrq[$];
  logic [15:0] e;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  sttf_taskfile #(.TICK_CYC(10)) sttf_taskfile_i (.*);
  sttf_core_model sttf_core_model_i (.CLK, .RST_B, .CMD_START, .CMPL_ACK, .dly, .end_addr(eaddr),
    .end_count(ecnt), .cmpl(CMPL));
  always #10 CLK = ~CLK;
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp, input logic [47:0] m);
    num_checks++;
    if ((got & m) !== (exp & m)) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    REG_SEL <= s;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [3:0] s, input logic [7:0] exp, input logic [7:0] m);
    expq.push_back({m, exp});
    REG_SEL <= s;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(posedge CLK);
  endtask
  function automatic logic [7:0] st(input logic busy, input logic err);
    return {busy, CORE_STAT.ready, 1'b0, CORE_STAT.seek_done, CORE_STAT.data_req, 1'b0, CORE_STAT.index, err};
  endfunction
  // address bytes go in before the command byte
  task automatic cmd(input logic [47:0] a, input logic [7:0] code, input logic go);
    wr(sttf_pkg::IDX_SECNUM, a[31:24]);
    wr(sttf_pkg::IDX_SECNUM, a[7:0]);
    wr(sttf_pkg::IDX_CYL_LOW, a[39:32]);
    wr(sttf_pkg::IDX_CYL_LOW, a[15:8]);
    wr(sttf_pkg::IDX_CYL_HIGH, a[47:40]);
    wr(sttf_pkg::IDX_CYL_HIGH, a[23:16]);
    if (go) addrq.push_back(a);
    wr(sttf_pkg::IDX_STAT_CMD, code);
  endtask
  task automatic wait_intr();
    int n;
    n = 0;
    while (INTRQ !== 1'b1 && n < 200) begin
      @(posedge CLK);
      n++;
    end
    if (n == 200) cmp(48'h0, 48'h1, 48'h1);
  endtask
  always @(posedge CLK) begin
    if (RST_B) cyc <= cyc + 1;
    rd_d <= REG_RD;
    if (rd_d) begin
      e = expq.pop_front();
      cmp({40'h0, REG_RDATA}, {40'h0, e[7:0]}, {40'h0, e[15:8]});
    end
    if (CMD_START === 1'b1) cmp(CMD_ADDR, addrq.size() > 0 ? addrq.pop_front() : ~CMD_ADDR, '1);
  end
  initial begin
    #(20 * 20000);
    error_cnt++;
    close_out();
  end
  initial begin
    logic [47:0] a;
    logic [7:0] codes[6];
    sttf_pkg::sttf_cond_t c;
    logic ab;
    logic [15:0] ec;
    void'($urandom(58));
    ec = sttf_pkg::COMPLETION_TIME_LIMIT_MIN_MS;
    codes = '{8'he5, 8'he5, 8'h92, 8'h93, 8'h25, 8'h25};
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    CORE_STAT <= 4'($urandom()) | 4'h8;
    @(posedge CLK);
    COMRESET_REQ <= 1'b1;
    @(posedge CLK);
    COMRESET_REQ <= 1'b0;
    while (COMINIT_SEND !== 1'b1 && cyc < 6000) @(posedge CLK);
    cmp(48'(cyc >= 4998 && cyc <= 5003), 48'h1, 48'h1);
    COMRESET_REQ <= 1'b1;
    @(posedge CLK);
    COMRESET_REQ <= 1'b0;
    @(posedge CLK);
    @(posedge CLK);
    cmp({47'h0, COMINIT_SEND}, 48'h1, 48'h1);
    rd(sttf_pkg::IDX_FEAT, sttf_pkg::RST_ERR, 8'hff);
    $display("test 1 done");
    for (int m = 0; m < 2; m++) begin
      a = 48'({$urandom(), $urandom()});
      eaddr <= 48'({$urandom(), $urandom()});
      dly <= 8'($urandom_range(9, 2));
      wr(sttf_pkg::IDX_DEVHEAD, 8'ha0 | (8'(m) << 6));
      cmd(a, 8'h24, 1'b1);
      rd(sttf_pkg::IDX_CYL_LOW, st(1'b1, 1'b0), 8'h80);
      rd(sttf_pkg::IDX_ALT_DEVCTL, st(1'b1, 1'b0), 8'h80);
      wait_intr();
      cmp({35'h0, CMD_HEAD, CMD_LBA_MODE, CMD_CODE}, {35'h0, 4'h0, 1'(m), 8'h24}, '1);
      rd(sttf_pkg::IDX_ALT_DEVCTL, st(1'b0, 1'b0), 8'hff);
      cmp({47'h0, INTRQ}, 48'h1, 48'h1);
      rd(sttf_pkg::IDX_STAT_CMD, st(1'b0, 1'b0), 8'hff);
      cmp({47'h0, INTRQ}, 48'h0, 48'h1);
      rd(sttf_pkg::IDX_CYL_LOW, eaddr[15:8], 8'hff);
      rd(sttf_pkg::IDX_CYL_HIGH, eaddr[23:16], 8'hff);
      wr(sttf_pkg::IDX_ALT_DEVCTL, 8'h80);
      rd(sttf_pkg::IDX_CYL_HIGH, eaddr[47:40], 8'hff);
      rd(sttf_pkg::IDX_CYL_LOW, eaddr[39:32], 8'hff);
      wr(sttf_pkg::IDX_ALT_DEVCTL, 8'h00);
    end
    $display("test 2 done");
    for (int i = 0; i < 6; i++) begin
      c = '0;
      c.idle = (i < 2);
      c.epc_enabled = (i == 1);
      c.sec_locked = (i == 2 || i == 3);
      c.erc_valid = (i > 3);
      c.erc_units = sttf_pkg::ERC_MIN_UNITS - 16'(i == 4);
      c.completion_time_limit_ms = 16'(i * 20);
      COND <= c;
      ab = (i > 1 && i < 5);
      ecnt <= 8'($urandom_range(8'h7f, 8'h01));
      cmd(48'({$urandom(), $urandom()}), codes[i], !ab);
      wait_intr();
      // aborted commands keep the previous limit
      if (!ab) ec = (i * 20 < 50) ? sttf_pkg::COMPLETION_TIME_LIMIT_MIN_MS : 16'(i * 20);
      cmp({32'h0, CMD_COMPLETION_TIME_LIMIT_MS}, {32'h0, ec}, '1);
      if (ab) rd(sttf_pkg::IDX_FEAT, 8'h04, 8'hff);
      if (i < 2) rd(sttf_pkg::IDX_COUNT, i == 1 ? 8'h80 : 8'hff, 8'hff);
      rd(sttf_pkg::IDX_STAT_CMD, st(1'b0, ab), 8'hff);
    end
    $display("test 3 done");
    wr(sttf_pkg::IDX_ALT_DEVCTL, 8'h04);
    cmp({47'h0, SOFT_RESET}, 48'h1, 48'h1);
    repeat (250) @(posedge CLK);
    wr(sttf_pkg::IDX_ALT_DEVCTL, 8'h00);
    cmp({47'h0, SOFT_RESET}, 48'h0, 48'h1);
    rd(sttf_pkg::IDX_FEAT, sttf_pkg::RST_ERR, 8'hff);
    repeat (3) @(posedge CLK);
    $display("test 4 done");
    close_out();
  end
endmodule // tb
